//--- pkg/serial_consts.svh
// Register indices, field positions, reset values and counts of the serial baud block.
`ifndef SERIAL_CONSTS_SVH
`define SERIAL_CONSTS_SVH
`define FLAGS_IDX     12'h118
`define RXDATA_IDX    12'h119
`define TXDATA_IDX    12'h11A
`define DIVIDER_IDX   12'h11B
`define RXCTRL_IDX    12'h11D
`define TXCTRL_IDX    12'h11E
`define BAUDCTRL_IDX  12'h11F
`define TXC_NINTH_EN  6
`define TXC_TX_EN     5
`define TXC_SYNC      4
`define TXC_HIGH      2
`define TXC_EMPTY     1
`define TXC_NINTH_BIT 0
`define RXC_PORT_EN   7
`define RXC_RX9       6
`define RXC_SINGLE    5
`define RXC_CONT      4
`define RXC_RX9D      0
`define BC_OVF        7
`define BC_IDLE       6
`define BC_POL        4
`define BC_WIDE       3
`define BC_WAKE       1
`define BC_ABD        0
`define BC_RSV_MASK   8'h24
`define FL_RECV       0
`define ZERO16        16'h0000
`define ONE16         16'h0001
`define PRE_4         16'h0003
`define PRE_16        16'h000F
`define PRE_64        16'h003F
`define BITS8         4'h8
`define BITS9         4'h9
`define AB_LAST       3'h3
`define AB_SH_4       5
`define AB_SH_16      7
`define AB_SH_64      9
`define LINE_IDLE     1'h1
`endif

//--- pkg/serial_pkg.sv
// State types of the serial baud and status block.
package serial_pkg;
   typedef enum {X_IDLE, X_START, X_DATA, X_STOP} xfer_state_t;
   typedef enum {R_IDLE, R_START, R_DATA, R_STOP} rx_state_t;
   typedef enum {AB_IDLE, AB_WAIT, AB_MEAS} ab_state_t;
endpackage : serial_pkg

//--- pkg/rate_if.sv
// Enable, limit and tick of one rate divider.
interface rate_if;
   logic        en;
   logic [15:0] limit;
   logic        tick;
   modport src (output en, output limit, input tick);
   modport div (input en, input limit, output tick);
endinterface : rate_if

//--- hdl/rate_divider.sv
// Counter that emits one tick every limit plus one enabled cycles.
`include "serial_consts.svh"
module rate_divider
  (
   input  wire logic core_clk_in,
   input  wire logic srst_in,
   input  wire logic clr_in,
   rate_if.div       ctl
   );
   logic [15:0] cnt_r;

   // Greater-or-equal keeps the divider from running away when the limit is lowered.
   assign ctl.tick = ctl.en && (cnt_r >= ctl.limit);

   always_ff @(posedge core_clk_in)
   begin
      if (srst_in || clr_in)
         cnt_r <= `ZERO16;
      else if (ctl.tick)
         cnt_r <= `ZERO16;
      else if (ctl.en)
         cnt_r <= cnt_r + `ONE16;
   end
endmodule : rate_divider

//--- hdl/line_sync.sv
// Two-flop synchroniser for a line pin with a falling-edge strobe.
`include "serial_consts.svh"
module line_sync
  (
   input  wire logic core_clk_in,
   input  wire logic srst_in,
   input  wire logic pin_in,
   output wire logic level_out,
   output wire logic fall_out
   );
   logic meta_r;
   logic sync_r;
   logic prev_r;

   assign level_out = sync_r;
   assign fall_out  = prev_r && !sync_r;

   always_ff @(posedge core_clk_in)
   begin
      if (srst_in)
      begin
         meta_r <= `LINE_IDLE;
         sync_r <= `LINE_IDLE;
         prev_r <= `LINE_IDLE;
      end
      else
      begin
         meta_r <= pin_in;
         sync_r <= meta_r;
         prev_r <= sync_r;
      end
   end
endmodule : line_sync

//--- hdl/serial_baud_ctrl.sv
// Serial port baud control, status and shift engines behind an APB slave.
// Function
// - Shift-empty status bit 1 shows idle shifter.
// - Writable ninth transmit bit at bit 0.
// - Clocked mode: receive enables beat transmit enable.
// - Async autobaud timer overflow sets read-only bit 7.
// - Async receiver idle flag at bit 6.
// - Async polarity bit inverts transmit, idling low.
// - Clocked mode: polarity picks active clock edge.
// - Width select chooses 16-bit or 8-bit divider.
// - Wake bit: falling edge sets flag, self-clears.
// - Autobaud enable starts detection, self-clears when done.
// - Async high speed: divide by 4 wide, else 16.
//
// Implementation choice: the APB slave port.
`include "serial_consts.svh"
module serial_baud_ctrl
   import serial_pkg::*;
  (
   input  wire logic        core_clk_in,
   input  wire logic        srst_in,
   input  wire logic [13:0] paddr_in,
   input  wire logic        psel_in,
   input  wire logic        penable_in,
   input  wire logic        pwrite_in,
   input  wire logic [31:0] pwdata_in,
   output logic      [31:0] prdata_out,
   output wire logic        pready_out,
   output wire logic        pslverr_out,
   input  wire logic        rx_in,
   output wire logic        tx_out,
   output wire logic        tx_oe_out,
   output wire logic        sclk_out,
   output wire logic        sclk_oe_out
   );
   logic        ninth_en_r, tx_en_r, sync_r, high_r, tx9_r;
   logic        port_en_r, rx9_r, single_rx_r, cont_rx_r;
   logic        pol_r, wide_r, wake_r, abd_r, ovf_r, flag_r, tx_pend_r;
   logic [7:0]  tx_data_r, rx_data_r;
   logic        rx_ninth_r;
   logic [15:0] divider_r;
   xfer_state_t x_state;
   logic [8:0]  shift_r, xin_r;
   logic [3:0]  xbit_r;
   logic        line_r, sclk_r, xrx_r;
   rx_state_t   r_state;
   logic [15:0] r_cnt_r;
   logic [8:0]  rsh_r;
   logic [3:0]  rbit_r;
   ab_state_t   ab_state;
   logic [15:0] ab_cnt_r;
   logic [2:0]  ab_edges_r;
   wire logic   rx_s, rx_fall;

   rate_if baud_bus ();
   rate_if bit_bus ();

   line_sync rx_sync (
      .core_clk_in (core_clk_in),
      .srst_in     (srst_in),
      .pin_in      (rx_in),
      .level_out   (rx_s),
      .fall_out    (rx_fall)
   );
   rate_divider baud_div (
      .core_clk_in (core_clk_in),
      .srst_in     (srst_in),
      .clr_in      (!port_en_r),
      .ctl         (baud_bus)
   );
   rate_divider bit_div (
      .core_clk_in (core_clk_in),
      .srst_in     (srst_in),
      .clr_in      (!port_en_r),
      .ctl         (bit_bus)
   );

   // Bus decode; the slave never stalls, so every access completes in its first access cycle.
   wire logic [11:0] idx      = paddr_in[13:2];
   wire logic        setup    = psel_in && !penable_in;
   wire logic        acc      = psel_in && penable_in;
   wire logic        hit_fl   = idx == `FLAGS_IDX;
   wire logic        hit_rxd  = idx == `RXDATA_IDX;
   wire logic        hit_txd  = idx == `TXDATA_IDX;
   wire logic        hit_div  = idx == `DIVIDER_IDX;
   wire logic        hit_rxc  = idx == `RXCTRL_IDX;
   wire logic        hit_txc  = idx == `TXCTRL_IDX;
   wire logic        hit_bc   = idx == `BAUDCTRL_IDX;
   wire logic        mapped   = hit_fl || hit_rxd || hit_txd || hit_div
                                || hit_rxc || hit_txc || hit_bc;
   wire logic        wr       = acc && pwrite_in && mapped;
   assign pready_out  = 1'h1;
   assign pslverr_out = acc && !mapped;

   // Rates.
   wire logic [15:0] bit_limit = sync_r ? `PRE_4 :
                                 high_r ? (wide_r ? `PRE_4 : `PRE_16) :
                                 (wide_r ? `PRE_16 : `PRE_64);
   assign baud_bus.en    = port_en_r;
   assign baud_bus.limit = wide_r ? divider_r : {8'h00, divider_r[7:0]};
   assign bit_bus.en     = baud_bus.tick;
   assign bit_bus.limit  = bit_limit;
   wire logic baud_tick  = baud_bus.tick;
   wire logic bit_tick   = bit_bus.tick;

   // Shift engine shared by asynchronous transmit and clocked transfers.
   wire logic       xfer_rx_sel = sync_r && (single_rx_r || cont_rx_r);
   wire logic       xfer_start  = bit_tick && x_state == X_IDLE
                                  && (xfer_rx_sel || (tx_en_r && tx_pend_r));
   wire logic [3:0] x_nbits     = (xrx_r ? rx9_r : ninth_en_r) ? `BITS9 : `BITS8;
   wire logic       x_active    = bit_tick && x_state == X_DATA && sync_r
                                  && (sclk_r != pol_r);
   wire logic       sync_done   = bit_tick && x_state == X_DATA && sync_r && !x_active
                                  && xbit_r == x_nbits;
   wire logic       tx_empty    = x_state == X_IDLE;

   always_ff @(posedge core_clk_in)
   begin
      if (srst_in || !port_en_r)
      begin
         x_state <= X_IDLE;
         shift_r <= 9'h000;
         xin_r   <= 9'h000;
         xbit_r  <= 4'h0;
         line_r  <= `LINE_IDLE;
         sclk_r  <= 1'h0;
         xrx_r   <= 1'h0;
      end
      else
         case (x_state)
            X_IDLE:
            begin
               sclk_r <= !pol_r;
               if (xfer_start)
               begin
                  shift_r <= {tx9_r, tx_data_r};
                  xbit_r  <= 4'h0;
                  xrx_r   <= xfer_rx_sel;
                  line_r  <= sync_r ? tx_data_r[0] : 1'h0;
                  x_state <= sync_r ? X_DATA : X_START;
               end
            end
            X_START:
               if (bit_tick)
               begin
                  line_r  <= shift_r[0];
                  shift_r <= {1'h0, shift_r[8:1]};
                  xbit_r  <= 4'h1;
                  x_state <= X_DATA;
               end
            X_DATA:
               if (bit_tick && sync_r)
               begin
                  sclk_r <= !sclk_r;
                  if (x_active)
                  begin
                     xin_r  <= {rx_s, xin_r[8:1]};
                     xbit_r <= xbit_r + 4'h1;
                  end
                  else if (xbit_r == x_nbits)
                     x_state <= X_IDLE;
                  else
                  begin
                     line_r  <= shift_r[1];
                     shift_r <= {1'h0, shift_r[8:1]};
                  end
               end
               else if (bit_tick)
               begin
                  if (xbit_r == x_nbits)
                  begin
                     line_r  <= `LINE_IDLE;
                     x_state <= X_STOP;
                  end
                  else
                  begin
                     line_r  <= shift_r[0];
                     shift_r <= {1'h0, shift_r[8:1]};
                     xbit_r  <= xbit_r + 4'h1;
                  end
               end
            X_STOP:
               if (bit_tick)
                  x_state <= X_IDLE;
            default:
               x_state <= X_IDLE;
         endcase
   end

   // Inversion applies only to the asynchronous line, so clocked data stays true.
   assign tx_out      = sync_r ? line_r : line_r ^ pol_r;
   assign tx_oe_out   = port_en_r && (!sync_r || (x_state != X_IDLE && !xrx_r));
   assign sclk_out    = sclk_r;
   assign sclk_oe_out = port_en_r && sync_r;

   // Asynchronous receiver, sampling mid-bit in baud ticks.
   wire logic       rx_go     = rx_fall && cont_rx_r && !sync_r && !wake_r && !abd_r
                                && r_state == R_IDLE;
   wire logic [3:0] r_nbits   = rx9_r ? `BITS9 : `BITS8;
   wire logic       r_zero    = r_cnt_r == `ZERO16;
   wire logic       rx_done   = baud_tick && r_state == R_STOP && r_zero;
   wire logic       rx_idle   = r_state == R_IDLE;

   always_ff @(posedge core_clk_in)
   begin
      if (srst_in || !port_en_r)
      begin
         r_state <= R_IDLE;
         r_cnt_r <= `ZERO16;
         rsh_r   <= 9'h000;
         rbit_r  <= 4'h0;
      end
      else
         case (r_state)
            R_IDLE:
               if (rx_go)
               begin
                  r_cnt_r <= {1'h0, bit_limit[15:1]};
                  rbit_r  <= 4'h0;
                  r_state <= R_START;
               end
            R_START, R_DATA, R_STOP:
               if (baud_tick && !r_zero)
                  r_cnt_r <= r_cnt_r - `ONE16;
               else if (baud_tick)
               begin
                  r_cnt_r <= bit_limit;
                  if (r_state == R_START)
                     r_state <= R_DATA;
                  else if (r_state == R_STOP)
                     r_state <= R_IDLE;
                  else
                  begin
                     rsh_r  <= {rx_s, rsh_r[8:1]};
                     rbit_r <= rbit_r + 4'h1;
                     if (rbit_r == r_nbits - 4'h1)
                        r_state <= R_STOP;
                  end
               end
            default:
               r_state <= R_IDLE;
         endcase
   end

   // Autobaud measures eight bit times of a 55h character from first to fifth falling edge.
   wire logic        ab_ovf_w  = ab_state == AB_MEAS && (&ab_cnt_r);
   wire logic        ab_done_w = ab_state == AB_MEAS && rx_fall && ab_edges_r == `AB_LAST;
   wire logic [15:0] ab_q      = (high_r && wide_r) ? (ab_cnt_r >> `AB_SH_4) :
                                 (high_r || wide_r) ? (ab_cnt_r >> `AB_SH_16) :
                                 (ab_cnt_r >> `AB_SH_64);
   wire logic [15:0] ab_result = ab_q - `ONE16;

   always_ff @(posedge core_clk_in)
   begin
      if (srst_in || !abd_r || sync_r)
      begin
         ab_state   <= AB_IDLE;
         ab_cnt_r   <= `ZERO16;
         ab_edges_r <= 3'h0;
      end
      else
         case (ab_state)
            AB_IDLE:
               ab_state <= AB_WAIT;
            AB_WAIT:
               if (rx_fall)
               begin
                  ab_cnt_r   <= `ONE16;
                  ab_edges_r <= 3'h0;
                  ab_state   <= AB_MEAS;
               end
            AB_MEAS:
            begin
               ab_cnt_r <= ab_cnt_r + `ONE16;
               if (rx_fall)
                  ab_edges_r <= ab_edges_r + 3'h1;
               if (ab_ovf_w || ab_done_w)
                  ab_state <= AB_IDLE;
            end
            default:
               ab_state <= AB_IDLE;
         endcase
   end

   // Register file; hardware updates follow software writes and win, except that a TXDATA write sets tx_pend_r after its clear.
   wire logic [15:0] rd_mux =
      hit_fl  ? {15'h0000, flag_r} :
      hit_rxd ? {8'h00, rx_data_r} :
      hit_txd ? {8'h00, tx_data_r} :
      hit_div ? divider_r :
      hit_rxc ? {8'h00, port_en_r, rx9_r, single_rx_r, cont_rx_r, 3'h0, rx_ninth_r} :
      hit_txc ? {8'h00, 1'h0, ninth_en_r, tx_en_r, sync_r, 1'h0, high_r, tx_empty, tx9_r} :
      hit_bc  ? {8'h00, ovf_r, rx_idle, 1'h0, pol_r, wide_r, 1'h0, wake_r, abd_r} :
      `ZERO16;

   always_ff @(posedge core_clk_in)
   begin
      if (srst_in)
         prdata_out <= 32'h00000000;
      else if (setup && !pwrite_in)
         prdata_out <= {16'h0000, rd_mux};
   end

   always_ff @(posedge core_clk_in)
   begin
      if (srst_in)
      begin
         {ninth_en_r, tx_en_r, sync_r, high_r, tx9_r} <= 5'h00;
         {port_en_r, rx9_r, single_rx_r, cont_rx_r}    <= 4'h0;
         {pol_r, wide_r, wake_r, abd_r, ovf_r}         <= 5'h00;
         {flag_r, tx_pend_r, rx_ninth_r}               <= 3'h0;
         tx_data_r <= 8'h00;
         rx_data_r <= 8'h00;
         divider_r <= `ZERO16;
      end
      else
      begin
         if (wr && hit_fl && pwdata_in[`FL_RECV])
            flag_r <= 1'h0;
         if (wr && hit_txd)
            tx_data_r <= pwdata_in[7:0];
         if (wr && hit_div)
            divider_r <= pwdata_in[15:0];
         if (wr && hit_txc)
         begin
            ninth_en_r <= pwdata_in[`TXC_NINTH_EN];
            tx_en_r    <= pwdata_in[`TXC_TX_EN];
            sync_r     <= pwdata_in[`TXC_SYNC];
            high_r     <= pwdata_in[`TXC_HIGH];
            tx9_r      <= pwdata_in[`TXC_NINTH_BIT];
         end
         if (wr && hit_rxc)
         begin
            port_en_r   <= pwdata_in[`RXC_PORT_EN];
            rx9_r       <= pwdata_in[`RXC_RX9];
            single_rx_r <= pwdata_in[`RXC_SINGLE];
            cont_rx_r   <= pwdata_in[`RXC_CONT];
         end
         if (wr && hit_bc)
         begin
            pol_r  <= pwdata_in[`BC_POL];
            wide_r <= pwdata_in[`BC_WIDE];
            wake_r <= pwdata_in[`BC_WAKE];
            abd_r  <= pwdata_in[`BC_ABD];
            if (pwdata_in[`BC_ABD])
               ovf_r <= 1'h0;
         end
         if (xfer_start && !xfer_rx_sel)
            tx_pend_r <= 1'h0;
         if (wr && hit_txd)
            tx_pend_r <= 1'h1;
         if (rx_done)
         begin
            rx_data_r  <= rx9_r ? rsh_r[7:0] : rsh_r[8:1];
            rx_ninth_r <= rsh_r[8];
            flag_r     <= 1'h1;
         end
         if (sync_done && xrx_r)
         begin
            rx_data_r  <= rx9_r ? xin_r[7:0] : xin_r[8:1];
            rx_ninth_r  <= xin_r[8];
            flag_r      <= 1'h1;
            single_rx_r <= 1'h0;
         end
         if (wake_r && !sync_r && rx_fall)
         begin
            flag_r <= 1'h1;
            wake_r <= 1'h0;
         end
         if (ab_done_w)
         begin
            divider_r <= ab_result;
            abd_r     <= 1'h0;
         end
         if (ab_ovf_w)
         begin
            ovf_r <= 1'h1;
            abd_r <= 1'h0;
         end
      end
   end

   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (srst_in);

   sequence wake_edge_s;
      wake_r && !sync_r && rx_fall;
   endsequence
   sequence wake_done_s;
      flag_r && !wake_r;
   endsequence

   empty_after_load_a: assert property (xfer_start |=> !tx_empty || !port_en_r)
      else $error("shift empty still set after load");
   ninth_write_a: assert property ((wr && hit_txc)
      |=> tx9_r == $past(pwdata_in[`TXC_NINTH_BIT]))
      else $error("ninth transmit bit not stored");
   rx_priority_a: assert property ((xfer_start && xfer_rx_sel) |=> xrx_r || !port_en_r)
      else $error("transmit taken over receive in clocked mode");
   ovf_flag_a: assert property (ab_ovf_w |=> ovf_r && !abd_r)
      else $error("autobaud overflow not flagged");
   rx_busy_a: assert property (rx_go |=> !rx_idle [*2] or (!port_en_r))
      else $error("receiver idle after start bit");
   idle_level_a: assert property ((!sync_r && tx_empty && port_en_r) |-> tx_out == !pol_r)
      else $error("async idle level wrong for polarity");
   clock_edge_a: assert property (x_active |=> sclk_r == pol_r || !port_en_r)
      else $error("clocked data on wrong edge");
   narrow_div_a: assert property (!wide_r |-> baud_bus.limit[15:8] == 8'h00)
      else $error("narrow divider uses high byte");
   wake_edge_a: assert property (wake_edge_s |=> wake_done_s)
      else $error("wake edge did not set flag and clear wake");
   abd_done_a: assert property (ab_done_w |=> !abd_r && divider_r == $past(ab_result))
      else $error("autobaud completion not applied");
   high_speed_a: assert property ((!sync_r && high_r)
      |-> bit_bus.limit == (wide_r ? `PRE_4 : `PRE_16))
      else $error("high speed prescale wrong");
   reserved_zero_a: assert property ((setup && !pwrite_in && hit_bc)
      |=> (prdata_out[7:0] & `BC_RSV_MASK) == 8'h00)
      else $error("unimplemented bits read nonzero");
endmodule : serial_baud_ctrl

//--- verif/line_partner.sv
// Far-end serial transceiver model that drives the receive line and decodes the transmit line.
module line_partner
  (
   input  wire logic core_clk_in,
   input  wire logic tx_line_in,
   output logic      rx_line_out
   );
   timeunit 1ns;
   timeprecision 1ns;
   // The line has a pull-up, so it rests high between frames.
   initial rx_line_out = 1'h1;
   task automatic send_byte(input logic [7:0] d, input int bit_cyc);
      logic [9:0] fr;
      fr = {1'h1, d, 1'h0};
      for (int i = 0; i < 10; i++)
      begin
         @(posedge core_clk_in);
         rx_line_out <= fr[i];
         repeat (bit_cyc - 1) @(posedge core_clk_in);
      end
   endtask : send_byte
   task automatic pulse(input int len);
      @(posedge core_clk_in);
      rx_line_out <= 1'h0;
      repeat (len) @(posedge core_clk_in);
      rx_line_out <= 1'h1;
   endtask : pulse
   // Samples mid-bit; gives up after a bounded wait so a silent line cannot hang the run.
   task automatic recv_byte(input int bit_cyc, output logic [7:0] d);
      int n;
      n = 0;
      d = 8'h00;
      while (tx_line_in !== 1'h0 && n < 1000)
      begin
         @(posedge core_clk_in);
         n++;
      end
      repeat (bit_cyc / 2) @(posedge core_clk_in);
      for (int i = 0; i < 8; i++)
      begin
         repeat (bit_cyc) @(posedge core_clk_in);
         d[i] = tx_line_in;
      end
   endtask : recv_byte
endmodule : line_partner

//--- verif/tb.sv
// Self-checking bench for the serial baud control block.
`include "serial_consts.svh"
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct {logic [11:0] idx; logic [31:0] wd; logic [31:0] mask; logic [31:0] exp;} row_t;
   logic        core_clk_in = 1'h0;
   logic        srst_in     = 1'h1;
   logic [13:0] paddr_in    = 14'h0000;
   logic        psel_in     = 1'h0;
   logic        penable_in  = 1'h0;
   logic        pwrite_in   = 1'h0;
   logic [31:0] pwdata_in   = 32'h00000000;
   logic [31:0] prdata_out;
   logic        pready_out;
   logic        pslverr_out;
   logic        rx_in;
   logic        tx_out;
   logic        tx_oe_out;
   logic        sclk_out;
   logic        sclk_oe_out;
   logic [31:0] rd;
   logic        err;
   logic [7:0]  got;
   logic        seen;
   int          n_mismatch;
   int          samples_checked;
   row_t        rows [4] = '{'{`TXCTRL_IDX, 32'h01, 32'hFF, 32'h03},
                             '{`BAUDCTRL_IDX, 32'h3C, 32'hBF, 32'h18},
                             '{`BAUDCTRL_IDX, 32'h00, 32'hBF, 32'h00},
                             '{`DIVIDER_IDX, 32'h1234, 32'hFFFF, 32'h1234}};
   serial_baud_ctrl DUT (.core_clk_in(core_clk_in), .srst_in(srst_in), .paddr_in(paddr_in),
      .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .pwdata_in(pwdata_in),
      .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
      .rx_in(rx_in), .tx_out(tx_out), .tx_oe_out(tx_oe_out), .sclk_out(sclk_out),
      .sclk_oe_out(sclk_oe_out));
   line_partner P (.core_clk_in(core_clk_in), .tx_line_in(tx_out), .rx_line_out(rx_in));
   always #50 core_clk_in = ~core_clk_in;
   task automatic cmp(input logic [31:0] g, input logic [31:0] e);
      samples_checked++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask : cmp
   task automatic apb(input logic w, input logic [11:0] idx, input logic [31:0] wd);
      @(posedge core_clk_in);
      psel_in    <= 1'h1;
      penable_in <= 1'h0;
      paddr_in   <= {idx, 2'h0};
      pwrite_in  <= w;
      pwdata_in  <= wd;
      @(posedge core_clk_in);
      penable_in <= 1'h1;
      do @(posedge core_clk_in); while (pready_out !== 1'h1);
      rd  = prdata_out;
      err = pslverr_out;
      psel_in    <= 1'h0;
      penable_in <= 1'h0;
   endtask : apb
   task automatic wr(input logic [11:0] idx, input logic [31:0] wd);
      apb(1'h1, idx, wd);
   endtask : wr
   task automatic rdr(input logic [11:0] idx);
      apb(1'h0, idx, 32'h0);
   endtask : rdr
   task automatic test_done;
      if (n_mismatch == 0 && samples_checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : test_done
   // The overflow wait alone takes about 66000 cycles.
   initial
   begin
      repeat (90000) @(posedge core_clk_in);
      n_mismatch++;
      test_done;
   end
   initial
   begin
      repeat (4) @(posedge core_clk_in);
      srst_in <= 1'h0;
      rdr(`TXCTRL_IDX);
      cmp(rd, 32'h02);
      foreach (rows[i])
      begin
         wr(rows[i].idx, rows[i].wd);
         rdr(rows[i].idx);
         cmp(rd & rows[i].mask, rows[i].exp);
      end
      wr(12'h11C, 32'hFF);
      cmp(err, 32'h1);
      rdr(12'h11C);
      cmp({err, rd[30:0]}, 32'h80000000);
      wr(`DIVIDER_IDX, 32'h3);
      wr(`BAUDCTRL_IDX, 32'h08);
      wr(`TXCTRL_IDX, 32'h24);
      wr(`RXCTRL_IDX, 32'h90);
      rdr(`BAUDCTRL_IDX);
      cmp(rd & 32'h40, 32'h40);
      cmp({tx_oe_out, tx_out}, 32'h3);
      wr(`BAUDCTRL_IDX, 32'h18);
      repeat (3) @(posedge core_clk_in);
      cmp(tx_out, 32'h0);
      wr(`BAUDCTRL_IDX, 32'h08);
      // Four baud ticks of four cycles give a sixteen-cycle bit.
      fork
         P.recv_byte(16, got);
         begin
            wr(`TXDATA_IDX, 32'hA5);
            repeat (20) @(posedge core_clk_in);
            rdr(`TXCTRL_IDX);
            cmp(rd & 32'h02, 32'h0);
         end
      join
      cmp(got, 32'hA5);
      repeat (40) @(posedge core_clk_in);
      rdr(`TXCTRL_IDX);
      cmp(rd & 32'h02, 32'h02);
      fork
         P.send_byte(8'h3C, 16);
         begin
            repeat (40) @(posedge core_clk_in);
            rdr(`BAUDCTRL_IDX);
            cmp(rd & 32'h40, 32'h0);
         end
      join
      repeat (30) @(posedge core_clk_in);
      rdr(`FLAGS_IDX);
      cmp(rd & 32'h1, 32'h1);
      rdr(`RXDATA_IDX);
      cmp(rd, 32'h3C);
      rdr(`BAUDCTRL_IDX);
      cmp(rd & 32'h40, 32'h40);
      wr(`FLAGS_IDX, 32'h1);
      wr(`BAUDCTRL_IDX, 32'h0A);
      P.pulse(40);
      repeat (10) @(posedge core_clk_in);
      rdr(`FLAGS_IDX);
      cmp(rd & 32'h1, 32'h1);
      rdr(`BAUDCTRL_IDX);
      cmp(rd & 32'h02, 32'h0);
      rdr(`RXDATA_IDX);
      cmp(rd, 32'h3C);
      wr(`FLAGS_IDX, 32'h1);
      // Eight bits of 68 cycles between first and fifth fall, shifted by five, less one.
      wr(`BAUDCTRL_IDX, 32'h09);
      P.send_byte(8'h55, 68);
      repeat (20) @(posedge core_clk_in);
      rdr(`DIVIDER_IDX);
      cmp(rd, 32'h10);
      rdr(`BAUDCTRL_IDX);
      cmp(rd & 32'h81, 32'h0);
      wr(`BAUDCTRL_IDX, 32'h09);
      P.pulse(20);
      repeat (65600) @(posedge core_clk_in);
      rdr(`BAUDCTRL_IDX);
      cmp(rd & 32'h81, 32'h80);
      wr(`DIVIDER_IDX, 32'h3);
      wr(`RXCTRL_IDX, 32'h80);
      wr(`BAUDCTRL_IDX, 32'h18);
      wr(`TXCTRL_IDX, 32'h30);
      repeat (4) @(posedge core_clk_in);
      cmp({sclk_oe_out, sclk_out}, 32'h2);
      wr(`BAUDCTRL_IDX, 32'h08);
      repeat (4) @(posedge core_clk_in);
      cmp({sclk_oe_out, sclk_out}, 32'h3);
      wr(`RXCTRL_IDX, 32'h90);
      wr(`TXDATA_IDX, 32'h5A);
      seen = 1'h0;
      repeat (200)
      begin
         @(posedge core_clk_in);
         seen = seen | (tx_oe_out !== 1'h0);
      end
      cmp(seen, 32'h0);
      srst_in <= 1'h1;
      repeat (3) @(posedge core_clk_in);
      srst_in <= 1'h0;
      rdr(`TXCTRL_IDX);
      cmp(rd, 32'h02);
      rdr(`BAUDCTRL_IDX);
      cmp(rd & 32'hBF, 32'h0);
      rdr(`DIVIDER_IDX);
      cmp(rd, 32'h0);
      test_done;
   end
endmodule : tb
